// ### hdl/adc_pacing_pkg.sv
// Shared constants and carrier types for the converter control block
package adc_pacing_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL  = 8'h00;
  localparam logic [7:0] OFF_LATEST   = 8'h04;
  localparam logic [7:0] OFF_QUEUE_CS = 8'h08;
  localparam logic [7:0] OFF_QUEUE_RD = 8'h0C;
  localparam logic [7:0] OFF_DIVIDER  = 8'h10;
  localparam logic [7:0] OFF_RAW_IRQ  = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_IRQ_FRC  = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STS  = 8'h20;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CS_EN       = 0;
  localparam int CS_BIAS     = 1;
  localparam int CS_ONCE     = 2;
  localparam int CS_MANY     = 3;
  localparam int CS_READY    = 8;
  localparam int CS_ERR      = 9;
  localparam int CS_ERR_STK  = 10;
  localparam int CS_CHAN_LSB = 12;
  localparam int QC_EN       = 0;
  localparam int QC_SHIFT    = 1;
  localparam int QC_ERR      = 2;
  localparam int QC_DREQ     = 3;
  localparam int QC_EMPTY    = 8;
  localparam int QC_FULL     = 9;
  localparam int QC_UNDER    = 10;
  localparam int QC_OVER     = 11;
  localparam int QC_LVL_LSB  = 16;
  localparam int QC_THR_LSB  = 24;
  localparam int QR_ERR      = 15;
  localparam int DIV_INT_LSB = 8;
  localparam int IRQ_THRESH  = 0;
  localparam int IRQ_DONE    = 1;
  // ----------------------------------------------------------------
  // Values and counts
  // ----------------------------------------------------------------
  localparam logic [2:0]  SENSOR_CHAN = 3'h4;
  localparam int unsigned CONV_CYCLES = 96;
  localparam logic [1:0]  IRQ_RST     = 2'h0;
  localparam logic [31:0] REG_RST     = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;

  // One conversion result as it travels into the queue
  typedef struct packed {
    logic        err;
    logic [11:0] value;
  } sample_t;

  // Control toward the analogue converter
  typedef struct packed {
    logic       power_en;
    logic       bias_en;
    logic       route_sensor;
    logic       start;
    logic [2:0] chan;
  } conv_ctrl_t;
endpackage

// ### hdl/pacing_divider.sv
// Fractional pacing divider with first-order delta-sigma dithering
`timescale 1ns/10ps
`default_nettype none
module pacing_divider
  import adc_pacing_pkg::*;
#(
  parameter int unsigned INT_W  = 16,
  parameter int unsigned FRAC_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              run,
  input  wire logic              restart,
  input  wire logic [INT_W-1:0]  div_int,
  input  wire logic [FRAC_W-1:0] div_frac,
  output logic                   tick
);
  if (INT_W < 2 || FRAC_W < 1)
  begin : g_bad
    $error("pacing_divider: widths too small");
  end

  typedef struct packed {
    logic [INT_W:0]    cnt;
    logic [FRAC_W-1:0] acc;
    logic              tick;
  } st_t;

  st_t              s_q;
  st_t              s_d;
  logic [FRAC_W:0]  sum;

  // ----------------------------------------------------------------
  // Count down; reload with int plus the accumulator carry
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    sum = {1'b0, s_q.acc} + {1'b0, div_frac};
    if (restart || !run)
    begin
      // Any divider write starts again from the initial state
      s_d.cnt = {1'b0, div_int};
      s_d.acc = '0;
    end
    else if (s_q.cnt == '0)
    begin
      s_d.tick = 1'b1;
      s_d.acc  = sum[FRAC_W-1:0];
      // Interval is int+1 or int+2, averaging 1+int+frac/256
      s_d.cnt  = {1'b0, div_int} + {{INT_W{1'b0}}, sum[FRAC_W]};
    end
    else
    begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;
endmodule
`default_nettype wire

// ### hdl/sample_fifo.sv
// Small flip-flop sample queue with level, full and empty
`timescale 1ns/10ps
`default_nettype none
module sample_fifo
  import adc_pacing_pkg::*;
#(
  parameter int unsigned DEPTH = 4,
  parameter int unsigned LVL_W = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             push,
  input  wire sample_t          push_data,
  input  wire logic             pop,
  output sample_t               pop_data,
  output logic [LVL_W-1:0]      level,
  output logic                  full,
  output logic                  empty
);
  localparam int unsigned IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << IDX_W) != DEPTH || DEPTH >= (1 << LVL_W))
  begin : g_bad
    $error("sample_fifo: depth must be a power of two below 2**LVL_W");
  end

  typedef struct packed {
    sample_t [DEPTH-1:0] mem;
    logic [IDX_W-1:0]    wr;
    logic [IDX_W-1:0]    rd;
    logic [LVL_W-1:0]    cnt;
  } st_t;

  st_t  s_q;
  st_t  s_d;
  logic do_push;
  logic do_pop;

  // ----------------------------------------------------------------
  // Push when not full, pop when not empty; both may coincide
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    do_push = push && (s_q.cnt != LVL_W'(DEPTH));
    do_pop  = pop && (s_q.cnt != '0);
    if (do_push)
    begin
      s_d.mem[s_q.wr] = push_data;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (do_pop)
      s_d.rd = s_q.rd + 1'b1;
    if (do_push && !do_pop)
      s_d.cnt = s_q.cnt + 1'b1;
    else if (do_pop && !do_push)
      s_d.cnt = s_q.cnt - 1'b1;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pop_data = s_q.mem[s_q.rd];
  assign level    = s_q.cnt;
  assign full     = (s_q.cnt == LVL_W'(DEPTH));
  assign empty    = (s_q.cnt == '0);
endmodule
`default_nettype wire

// ### hdl/adc_pacing_ctrl.sv
// Converter controller: register map, pacing, sample queue, interrupts
// Behaviour
// - Channel four routes sensor diode to converter
// - Nonzero divider paces free-running conversion starts
// - Divider write restarts the pacing count
// - Average pacing tick period is 1+int+frac/256 cycles
// - Status is raw AND mask OR force
// - Latest sample register holds last conversion
// - Zero divider: back-to-back, one per 96
// - Fraction dithers interval between int+1, int+2
// - Pacing tick during conversion, except its last cycle, is dropped
// - Raw interrupt while level at/above threshold
`timescale 1ns/10ps
`default_nettype none
module adc_pacing_ctrl
  import adc_pacing_pkg::*;
#(
  parameter int unsigned QUEUE_DEPTH = 4
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output conv_ctrl_t       conv_ctrl,
  input  wire sample_t     conv_result,
  output logic             irq,
  output logic             dreq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        en;
    logic        bias;
    logic        many;
    logic [2:0]  chan;
    logic        err_last;
    logic        err_stk;
    logic [11:0] latest;
    logic        q_en;
    logic        q_shift;
    logic        q_err;
    logic        q_dreq;
    logic        under;
    logic        over;
    logic [3:0]  thresh;
    logic [15:0] div_int;
    logic [7:0]  div_frac;
    logic [1:0]  mask;
    logic [1:0]  force_irq;
    logic        done_flag;
    logic        busy;
    logic [6:0]  ccnt;
    logic        start;
    logic        aw_held;
    logic [7:0]  awaddr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
  } st_t;

  st_t         s_q;
  st_t         s_d;
  logic        pace_tick;
  logic        div_restart;
  logic        pace_run;
  logic        q_push;
  logic        q_pop;
  sample_t     q_in;
  sample_t     q_out;
  logic [3:0]  q_level;
  logic        q_full;
  logic        q_empty;
  logic [1:0]  raw;
  logic [1:0]  status;
  logic [31:0] rd;
  logic [31:0] wm;
  logic [31:0] w1;
  logic        wr_go;
  logic        ar_go;
  logic        finishing;
  logic        free;
  logic        launch;
  logic        div_zero;
  logic        once_req;

  // Byte lanes of a write strobe as a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Merge written lanes over the old register value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    merge = (old & ~lane_mask(strb)) | (nw & lane_mask(strb));
  endfunction

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  pacing_divider #(
    .INT_W  (16),
    .FRAC_W (8)
  ) u_pace (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (pace_run),
    .restart  (div_restart),
    .div_int  (s_q.div_int),
    .div_frac (s_q.div_frac),
    .tick     (pace_tick)
  );

  sample_fifo #(
    .DEPTH (QUEUE_DEPTH),
    .LVL_W (4)
  ) u_queue (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .push      (q_push),
    .push_data (q_in),
    .pop       (q_pop),
    .pop_data  (q_out),
    .level     (q_level),
    .full      (q_full),
    .empty     (q_empty)
  );

  // Interrupt sources and the masked, forced status
  assign raw[IRQ_THRESH] = (q_level >= s_q.thresh);
  assign raw[IRQ_DONE]   = s_q.done_flag;
  assign status          = (raw & s_q.mask) | s_q.force_irq;
  assign div_zero        = (s_q.div_int == '0) && (s_q.div_frac == '0);
  assign pace_run        = s_q.en && s_q.many && !div_zero;

  // ----------------------------------------------------------------
  // Read data mux; unmapped offsets read zero
  // ----------------------------------------------------------------
  always_comb
  begin
    rd = REG_RST;
    unique case (s_axi_araddr)
      OFF_CONTROL:
      begin
        rd[CS_EN]      = s_q.en;
        rd[CS_BIAS]    = s_q.bias;
        rd[CS_MANY]    = s_q.many;
        rd[CS_READY]   = s_q.en && !s_q.busy;
        rd[CS_ERR]     = s_q.err_last;
        rd[CS_ERR_STK] = s_q.err_stk;
        rd[CS_CHAN_LSB +: 3] = s_q.chan;
      end
      OFF_LATEST:   rd[11:0] = s_q.latest;
      OFF_QUEUE_CS:
      begin
        rd[QC_EN]    = s_q.q_en;
        rd[QC_SHIFT] = s_q.q_shift;
        rd[QC_ERR]   = s_q.q_err;
        rd[QC_DREQ]  = s_q.q_dreq;
        rd[QC_EMPTY] = q_empty;
        rd[QC_FULL]  = q_full;
        rd[QC_UNDER] = s_q.under;
        rd[QC_OVER]  = s_q.over;
        rd[QC_LVL_LSB +: 4] = q_level;
        rd[QC_THR_LSB +: 4] = s_q.thresh;
      end
      OFF_QUEUE_RD:
      begin
        rd[QR_ERR] = q_out.err;
        rd[11:0]   = q_out.value;
      end
      OFF_DIVIDER:  rd[23:0] = {s_q.div_int, s_q.div_frac};
      OFF_RAW_IRQ:  rd[1:0]  = raw;
      OFF_IRQ_MASK: rd[1:0]  = s_q.mask;
      OFF_IRQ_FRC:  rd[1:0]  = s_q.force_irq;
      OFF_IRQ_STS:  rd[1:0]  = status;
      default:      rd = REG_RST;
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic: bus, registers, conversion sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.start = 1'b0;
    // Handshakes; write address and data are held until both arrive
    ar_go = s_axi_arvalid && !s_q.rvalid;
    wr_go = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    if (s_axi_awvalid && !s_q.aw_held && !s_q.bvalid)
    begin
      s_d.aw_held = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_held && !s_q.bvalid)
    begin
      s_d.w_held = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    if (ar_go)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd;
    end
    // Read side effects: pop the queue, clear the sticky done flag
    q_pop = ar_go && (s_axi_araddr == OFF_QUEUE_RD);
    if (ar_go && (s_axi_araddr == OFF_RAW_IRQ))
      s_d.done_flag = 1'b0;

    // Register writes
    wm = merge(REG_RST, s_q.wdata, s_q.wstrb);
    w1 = s_q.wdata & lane_mask(s_q.wstrb);
    div_restart = 1'b0;
    once_req = 1'b0;
    if (wr_go)
    begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      unique case (s_q.awaddr)
        OFF_CONTROL:
        begin
          wm = merge({17'h0, s_q.chan, 8'h0, s_q.many, 1'b0, s_q.bias, s_q.en},
                     s_q.wdata, s_q.wstrb);
          s_d.en   = wm[CS_EN];
          s_d.bias = wm[CS_BIAS];
          s_d.many = wm[CS_MANY];
          s_d.chan = wm[CS_CHAN_LSB +: 3];
          // Single start is self-clearing and ignored in free-running mode
          once_req = w1[CS_ONCE] && !wm[CS_MANY];
          if (w1[CS_ERR_STK])
            s_d.err_stk = 1'b0;
        end
        OFF_QUEUE_CS:
        begin
          wm = merge({4'h0, s_q.thresh, 20'h0, s_q.q_dreq, s_q.q_err,
                      s_q.q_shift, s_q.q_en}, s_q.wdata, s_q.wstrb);
          s_d.q_en    = wm[QC_EN];
          s_d.q_shift = wm[QC_SHIFT];
          s_d.q_err   = wm[QC_ERR];
          s_d.q_dreq  = wm[QC_DREQ];
          s_d.thresh  = wm[QC_THR_LSB +: 4];
          if (w1[QC_UNDER])
            s_d.under = 1'b0;
          if (w1[QC_OVER])
            s_d.over = 1'b0;
        end
        OFF_DIVIDER:
        begin
          wm = merge({8'h0, s_q.div_int, s_q.div_frac}, s_q.wdata, s_q.wstrb);
          s_d.div_int  = wm[DIV_INT_LSB +: 16];
          s_d.div_frac = wm[7:0];
          div_restart  = 1'b1;
        end
        OFF_IRQ_MASK: s_d.mask      = wm[1:0];
        OFF_IRQ_FRC:  s_d.force_irq = wm[1:0];
        default:      s_d.busy      = s_q.busy;
      endcase
    end
    // Underflow set comes after its clear so a same-cycle set wins
    if (q_pop && q_empty)
      s_d.under = 1'b1;

    // Conversion: the last count cycle can also launch the next one
    finishing = s_q.busy && (s_q.ccnt == '0);
    free      = !s_q.busy || finishing;
    // Ticks that land while busy, before the last count cycle, are dropped, not queued
    launch = s_q.en && free && (once_req || (s_q.many &&
             (div_zero || pace_tick)));
    q_in.err   = s_q.q_err && conv_result.err;
    q_in.value = s_q.q_shift ? {4'h0, conv_result.value[11:4]} : conv_result.value;
    q_push = finishing && s_q.q_en;
    if (finishing)
    begin
      s_d.busy      = 1'b0;
      s_d.latest    = conv_result.value;
      s_d.err_last  = conv_result.err;
      s_d.done_flag = 1'b1;
      if (conv_result.err)
        s_d.err_stk = 1'b1;
      // A full queue keeps its contents and drops this sample
      if (q_push && q_full)
        s_d.over = 1'b1;
    end
    else if (s_q.busy)
      s_d.ccnt = s_q.ccnt - 1'b1;
    if (launch)
    begin
      s_d.busy  = 1'b1;
      s_d.start = 1'b1;
      s_d.ccnt  = 7'(CONV_CYCLES - 1);
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_held && !s_q.bvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = RESP_OKAY;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = RESP_OKAY;

  // Converter control; bias is software's job, never tied to power
  assign conv_ctrl.power_en     = s_q.en;
  assign conv_ctrl.bias_en      = s_q.bias;
  assign conv_ctrl.route_sensor = (s_q.chan == SENSOR_CHAN);
  assign conv_ctrl.start        = s_q.start;
  assign conv_ctrl.chan         = s_q.chan;

  assign irq  = |status;
  assign dreq = s_q.q_dreq && raw[IRQ_THRESH] && !q_empty;
endmodule
`default_nettype wire

// ### tb/adc_pacing_asserts.sv
// Port-level assertions for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adc_pacing_asserts
  import adc_pacing_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire conv_ctrl_t  conv_ctrl
);
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  // ----------------------------------------------------------------
  // Cycles since the last start pulse, saturating
  // ----------------------------------------------------------------
  // Saturation keeps a long idle spell from wrapping into a false gap
  always_comb
  begin
    gap_d = gap_q;
    if (conv_ctrl.start)
      gap_d = 8'h01;
    else if (gap_q != 8'hFF)
      gap_d = gap_q + 8'h01;
  end
  // Counter register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gap_q <= 8'hFF;
    else
      gap_q <= gap_d;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  route_sense_a: assert property (
    conv_ctrl.route_sensor == (conv_ctrl.chan == SENSOR_CHAN)) else $error("sensor route wrong");
  start_power_a: assert property (
    conv_ctrl.start |-> conv_ctrl.power_en) else $error("start while powered down");
  start_gap_a: assert property (
    conv_ctrl.start |-> gap_q >= 8'h60) else $error("start inside busy window");
  start_pulse_a: assert property (
    conv_ctrl.start |=> !conv_ctrl.start) else $error("start pulse too long");
  wr_hold_a: assert property (
    wr_wait |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rd_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  wr_busy_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  rd_answer_a: assert property (
    rd_take |=> s_axi_rvalid ##0 !s_axi_arready) else $error("read answer late");
endmodule
bind adc_pacing_ctrl adc_pacing_asserts chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .conv_ctrl(conv_ctrl));
`default_nettype wire

// ### tb/conv_model.sv
// Behavioural model of the analogue converter and sensor behind the block
`timescale 1ns/10ps
`default_nettype none
module conv_model
  import adc_pacing_pkg::*;
#(
  parameter logic [11:0] SENSOR_VAL = 12'h37B
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire conv_ctrl_t ctrl,
  output sample_t         res
);
  logic [6:0]  left_q;
  logic        err_q;
  logic [11:0] val_q;
  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  // A start loads a fresh value that stands for the whole conversion
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      left_q <= 7'h00;
      err_q  <= 1'b0;
      val_q  <= 12'h5A3;
    end
    else if (ctrl.start)
    begin
      left_q <= 7'h60;
      err_q  <= ctrl.route_sensor && !ctrl.bias_en;
      val_q  <= ctrl.route_sensor ? SENSOR_VAL : val_q + 12'h123;
    end
    else if (left_q != 7'h00)
      left_q <= left_q - 7'h01;
  end
  // Outside a conversion the output is inverted so a late sample shows
  assign res = (left_q != 7'h00) ? {err_q, val_q} : ~{err_q, val_q};
endmodule
`default_nettype wire

// ### tb/test_adc_pacing_ctrl.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t %s", $time, m); end end
module test_adc_pacing_ctrl
  import adc_pacing_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  aw_a = 8'h00;
  logic [7:0]  ar_a = 8'h00;
  logic [31:0] w_d = 32'h0;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        bre = 1'b0;
  logic        arv = 1'b0;
  logic        rre = 1'b0;
  logic        awr, wrd, bv, arr, rv, irq, dreq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdat;
  conv_ctrl_t  cc;
  sample_t     res;
  int          checks = 0;
  int          n_mismatch = 0;
  int          cyc = 0;
  adc_pacing_ctrl dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ar_a), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .conv_ctrl(cc), .conv_result(res), .irq(irq), .dreq(dreq));
  conv_model conv (.aclk(aclk), .aresetn(aresetn), .ctrl(cc), .res(res));
  // ----------------------------------------------------------------
  // Clock, cycle count and bus tasks
  // ----------------------------------------------------------------
  initial
  begin
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  // Address and data are offered together and each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    aw_a <= a;
    w_d <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awv && awr)
      begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wrd)
      begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    while (!(ad && dd));
    while (!bv) @(posedge aclk);
    // Late bready leaves the response waiting one cycle
    bre <= 1'b1;
    @(posedge aclk);
    bre <= 1'b0;
    `CHK(bresp, RESP_OKAY, "write response")
  endtask
  // Read one word and compare it
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    @(posedge aclk);
    ar_a <= a;
    arv <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    while (!rv) @(posedge aclk);
    rre <= 1'b1;
    @(posedge aclk);
    rre <= 1'b0;
    `CHK(rdat, e, m)
    `CHK(rresp, RESP_OKAY, m)
  endtask
  // Wait for a start pulse and note the cycle
  task automatic wst(output int t);
    do @(posedge aclk); while (!cc.start);
    t = cyc;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_map;
    rdc(OFF_CONTROL, 32'h0, "control reset");
    rdc(OFF_QUEUE_CS, 32'h100, "queue reset");
    rdc(OFF_QUEUE_RD, 32'h0, "empty pop");
    rdc(OFF_QUEUE_CS, 32'h500, "underflow flag");
    wr(OFF_QUEUE_CS, 32'h400);
    rdc(OFF_QUEUE_CS, 32'h100, "underflow clear");
    rdc(OFF_RAW_IRQ, 32'h1, "raw reset");
    rdc(OFF_IRQ_STS, 32'h0, "status reset");
    wr(OFF_DIVIDER, 32'hFFFF_FFFF);
    rdc(OFF_DIVIDER, 32'h00FF_FFFF, "divider fields");
    wr(OFF_DIVIDER, 32'h0);
    wr(8'h24, 32'hFFFF_FFFF);
    rdc(8'h24, 32'h0, "unmapped read");
    rdc(8'hFC, 32'h0, "far unmapped");
    $display("test reset_map done");
  endtask
  // Force, mask and raw combine into status and the pin
  task automatic t_irq;
    wr(OFF_IRQ_FRC, 32'hFFFF_FFFF);
    rdc(OFF_IRQ_STS, 32'h3, "forced status");
    `CHK(irq, 1'b1, "forced irq")
    wr(OFF_IRQ_FRC, 32'h0);
    `CHK(irq, 1'b0, "unforced irq")
    wr(OFF_IRQ_MASK, 32'h1);
    rdc(OFF_IRQ_STS, 32'h1, "masked raw");
    `CHK(irq, 1'b1, "raw irq")
    wr(OFF_IRQ_MASK, 32'h2);
    `CHK(irq, 1'b0, "masked off")
    $display("test irq done");
  endtask
  // Sensor channel one-shot with bias on first
  task automatic t_sensor;
    wr(OFF_CONTROL, 32'h4003);
    `CHK(cc.route_sensor, 1'b1, "sensor route")
    `CHK(cc.bias_en, 1'b1, "bias on")
    rdc(OFF_CONTROL, 32'h4103, "control ready");
    wr(OFF_CONTROL, 32'h4007);
    repeat (100) @(posedge aclk);
    rdc(OFF_LATEST, {20'h0, conv.val_q}, "sensor sample");
    `CHK(conv.err_q, 1'b0, "bias ready")
    `CHK(irq, 1'b1, "done irq")
    rdc(OFF_RAW_IRQ, 32'h3, "raw done");
    rdc(OFF_RAW_IRQ, 32'h1, "done cleared");
    `CHK(irq, 1'b0, "done irq off")
    wr(OFF_IRQ_MASK, 32'h0);
    $display("test sensor done");
  endtask
  // Free running with a given divider, check two start gaps
  task automatic t_pace(input logic [31:0] dv, input int g1, input int g2);
    int a;
    int b;
    int c;
    logic [11:0] v;
    wr(OFF_DIVIDER, dv);
    wr(OFF_CONTROL, 32'h9);
    wst(a);
    wst(b);
    wst(c);
    v = conv.val_q;
    `CHK(b - a >= g1 && b - a <= g2, 1'b1, "pacing gap")
    `CHK(c - a, g1 + g2, "average period")
    rdc(OFF_LATEST, {20'h0, v}, "latest free run");
    wr(OFF_CONTROL, 32'h1);
    repeat (100) @(posedge aclk);
    $display("test pace done");
  endtask
  // Queue threshold drives the raw bit and the pin
  task automatic t_queue;
    logic [11:0] v1;
    wr(OFF_QUEUE_CS, 32'h0200_0009);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_CONTROL, 32'h5);
    repeat (100) @(posedge aclk);
    v1 = conv.val_q;
    `CHK(irq, 1'b0, "below threshold")
    wr(OFF_CONTROL, 32'h5);
    repeat (100) @(posedge aclk);
    `CHK(irq, 1'b1, "at threshold")
    `CHK(dreq, 1'b1, "dreq at threshold")
    rdc(OFF_QUEUE_CS, 32'h0202_0009, "level two");
    rdc(OFF_QUEUE_RD, {20'h0, v1}, "first queued");
    `CHK(irq, 1'b0, "drained below")
    `CHK(dreq, 1'b0, "dreq drained")
    rdc(OFF_QUEUE_RD, {20'h0, conv.val_q}, "second queued");
    $display("test queue done");
  endtask
  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog sized well past the roughly 1,650 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    complete_run;
  end
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_map;
    t_irq;
    t_sensor;
    t_pace(32'h0, 96, 96);
    t_pace(32'h3100, 100, 100);
    t_pace(32'h6480, 101, 102);
    t_queue;
    complete_run;
  end
endmodule
`default_nettype wire
